// >>> rtl/aps_pin_select.v
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`include "aps_regs.vh"
// Notes on behaviour
// - a readable status flag tells if the external clock runs the system.
// - implemented selection bits are read/write and reset to zero.
// - bit 4 and bits 1:0 of the pin selection register read as zero.
// - receive/data select bit 7 cleared puts receive/data on RC5.
// - on 20-pin parts the output select bit reads zero; output is on RC7.
// - on 20-pin parts slave select bit reads zero; its input is on RC6.
`default_nettype none
module aps_pin_select #(
	parameter PIN20 = 0
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// axi4-lite write address
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [3:0]  s_axi_awaddr,
	// axi4-lite write data
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	// axi4-lite read address
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	input  wire [3:0]  s_axi_araddr,
	// axi4-lite read data
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	// clock status from the start-up sequencer
	input  wire        ext_osc_running_flag,
	// selection bits driving the pin multiplexer
	output reg         rx_data_pin_sel,
	output reg         serial_out_pin_sel,
	output reg         slave_select_pin_sel,
	output reg         timer_gate_pin_sel,
	output reg         tx_clock_pin_sel
);
	// writable-bit mask for this package variant
	wire [7:0]  wmask;
	// handshake strobes, one per channel, and the write commit strobe
	wire        aw_take;
	wire        w_take;
	wire        ar_take;
	wire        b_done;
	wire        r_done;
	wire        wr_commit;
	// stored selection bits and their next value
	reg  [7:0]  pinsel_ff;
	reg  [7:0]  nxt_pinsel;
	// write halves held until the response is taken
	reg         aw_ff;
	reg         w_ff;
	reg  [3:0]  awaddr_ff;
	reg  [7:0]  wdata_ff;
	reg         wstrb0_ff;
	// oscillator status as seen by the read path
	reg         ext_osc_ff;

	aps_sel_mask #(
		.PIN20 (PIN20)
	) u_mask (
		.mask  (wmask)
	);

	// address decode shared by the write and the read response;
	// anything outside the two words answers with an error
	function addr_ok;
		input [3:0] a;
		begin
			addr_ok = (a == `APS_ADDR_PINSEL) ||
			          (a == `APS_ADDR_OSC_STATUS);
		end
	endfunction

	// response code for a decoded address
	function [1:0] resp_of;
		input [3:0] a;
		begin
			if (addr_ok(a))
				resp_of = `APS_RESP_OKAY;
			else
				resp_of = `APS_RESP_SLVERR;
		end
	endfunction

	// register read decode; unmapped words read as zero
	function [31:0] rd_val;
		input [3:0] a;
		input [7:0] sel;
		input       osc;
		begin
			rd_val = 32'h00000000;
			case (a)
			`APS_ADDR_PINSEL:
				rd_val[7:0] = sel;
			`APS_ADDR_OSC_STATUS:
				rd_val[`APS_BIT_EXTOSC] = osc;
			default:
				rd_val = 32'h00000000;
			endcase
		end
	endfunction

	// a channel moves at the edge where its valid and ready are both high
	assign aw_take   = s_axi_awvalid && s_axi_awready;
	assign w_take    = s_axi_wvalid && s_axi_wready;
	assign ar_take   = s_axi_arvalid && s_axi_arready;
	assign b_done    = s_axi_bvalid && s_axi_bready;
	assign r_done    = s_axi_rvalid && s_axi_rready;
	// both halves held and no answer out yet: this cycle commits the write
	assign wr_commit = aw_ff && w_ff && !s_axi_bvalid;

	// masked write; bits outside the mask stay zero so unimplemented
	// and read-only positions can never be set from software
	always @* begin
		nxt_pinsel = pinsel_ff;
		if (wr_commit && wstrb0_ff && awaddr_ff == `APS_ADDR_PINSEL)
			nxt_pinsel = wdata_ff & wmask;
	end

	// selection register; cleared by any reset
	always @(posedge clk) begin
		if (rst)
			pinsel_ff <= `APS_PINSEL_RESET;
		else
			pinsel_ff <= nxt_pinsel;
	end

	// write readies pulse for one cycle and stay low while their own half is
	// held or the response is pending; the pulse keeps a stalled master
	// from having two words accepted back to back
	always @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_ff && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_ff && !s_axi_wready && !s_axi_bvalid;
		end
	end

	// address half, captured in either order, freed by the response
	always @(posedge clk) begin
		if (rst) begin
			aw_ff     <= 1'b0;
			awaddr_ff <= 4'h0;
		end else if (aw_take) begin
			aw_ff     <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end else if (b_done) begin
			aw_ff     <= 1'b0;
		end
	end

	// data half; only the low byte and its strobe matter here
	always @(posedge clk) begin
		if (rst) begin
			w_ff      <= 1'b0;
			wdata_ff  <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else if (w_take) begin
			w_ff      <= 1'b1;
			wdata_ff  <= s_axi_wdata[7:0];
			wstrb0_ff <= s_axi_wstrb[0];
		end else if (b_done) begin
			w_ff      <= 1'b0;
		end
	end

	// response one edge after both halves are held; the selection
	// register takes its new value at that same edge
	always @(posedge clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `APS_RESP_OKAY;
		end else if (wr_commit) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= resp_of(awaddr_ff);
		end else if (b_done) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read address ready; low while data waits, so one read is open
	always @(posedge clk) begin
		if (rst)
			s_axi_arready <= 1'b0;
		else
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
	end

	// flag is registered once so the read word comes from a flop; the
	// price is one cycle of lag behind the input
	always @(posedge clk) begin
		if (rst)
			ext_osc_ff <= 1'b0;
		else
			ext_osc_ff <= ext_osc_running_flag;
	end

	// read data one edge after the address, held until taken
	always @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `APS_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val(s_axi_araddr, pinsel_ff,
			                       ext_osc_ff);
			s_axi_rresp  <= resp_of(s_axi_araddr);
		end else if (r_done) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// pin routing follows the stored bits one edge later, so every
	// selection line comes straight from a flop
	always @(posedge clk) begin
		if (rst) begin
			rx_data_pin_sel      <= 1'b0; // receive on RC5
			serial_out_pin_sel   <= 1'b0;
			slave_select_pin_sel <= 1'b0;
			timer_gate_pin_sel   <= 1'b0;
			tx_clock_pin_sel     <= 1'b0;
		end else begin
			rx_data_pin_sel      <= pinsel_ff[`APS_BIT_RX];
			serial_out_pin_sel   <= pinsel_ff[`APS_BIT_SOUT];
			slave_select_pin_sel <= pinsel_ff[`APS_BIT_SSEL];
			timer_gate_pin_sel   <= pinsel_ff[`APS_BIT_GATE];
			tx_clock_pin_sel     <= pinsel_ff[`APS_BIT_TXC];
		end
	end
endmodule // aps_pin_select
`default_nettype wire

// >>> rtl/aps_regs.vh
`ifndef APS_REGS_VH
`define APS_REGS_VH
// register byte addresses (own layout)
`define APS_ADDR_PINSEL     4'h0
`define APS_ADDR_OSC_STATUS 4'h4
// pin selection fields
`define APS_BIT_RX          7
`define APS_BIT_SOUT        6
`define APS_BIT_SSEL        5
`define APS_BIT_GATE        3
`define APS_BIT_TXC         2
`define APS_PINSEL_RESET    8'h00
// writable mask per variant: 14-pin has bits 7,6,5,3,2; 20-pin drops 6,5
`define APS_MASK_14PIN     8'hec
`define APS_MASK_20PIN     8'h8c
// oscillator status field
`define APS_BIT_EXTOSC     0
// axi responses
`define APS_RESP_OKAY      2'h0
`define APS_RESP_SLVERR    2'h2
`endif

// >>> rtl/aps_sel_mask.v
`include "aps_regs.vh"
`default_nettype none
// writable-bit mask for the chosen package variant
module aps_sel_mask #(
	parameter PIN20 = 0
) (
	// mask out
	output wire [7:0] mask
);
	// 20-pin parts tie output and slave select to fixed pins
	assign mask = PIN20 ? `APS_MASK_20PIN : `APS_MASK_14PIN;
endmodule // aps_sel_mask
`default_nettype wire

// >>> tb/aps_pin_select_checker.sv
`default_nettype none
module aps_pin_select_checker (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// write channel handshakes
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// read channel
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// routing
	input wire logic        rx_data_pin_sel
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// reset must clear answers and routing within one edge
	property p_rst; disable iff (1'b0)
		rst |=> !s_axi_bvalid && !s_axi_rvalid && !rx_data_pin_sel; endproperty
	a_rst: assert property (p_rst) else $error("reset left state");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("rdata moved");
	property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_arblk: assert property (p_arblk) else $error("arready early");
	// unimplemented bits 31:8, 4 and 1 never read back as one
	property p_zero;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[4]
			&& !s_axi_rdata[1];
	endproperty
	a_zero: assert property (p_zero) else $error("reserved bit set");
	property p_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_ans: assert property (p_ans) else $error("read late");
	property p_wblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_wblk: assert property (p_wblk) else $error("ready early");
	// routing only moves right after a completed write or a reset
	property p_pin;
		$changed(rx_data_pin_sel) |-> $past(s_axi_bvalid) || $past(rst);
	endproperty
	a_pin: assert property (p_pin) else $error("stray route");
endmodule // aps_pin_select_checker
`default_nettype wire

// >>> tb/aps_pin_select_tb.sv
`default_nettype none
module aps_pin_select_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0;
	logic        rry = 0, osc = 0;
	logic [3:0]  awa = 0, ara = 0, ws = 4'hf;
	logic [31:0] wd = 0, d;
	logic        awr, wrd, bv, arr, rv;
	logic [1:0]  br, rr;
	logic [31:0] rd;
	logic [4:0]  sel;
	logic [31:0] q[$];
	logic [31:0] rd2, q2[$];
	logic [4:0]  sel2;
	logic [1:0]  qb[$], qr[$];
	int          n_mismatch = 0, checks_done = 0;
	aps_pin_select dut (.clk(clk), .rst(rst), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .ext_osc_running_flag(osc),
		.rx_data_pin_sel(sel[4]), .serial_out_pin_sel(sel[3]),
		.slave_select_pin_sel(sel[2]), .timer_gate_pin_sel(sel[1]),
		.tx_clock_pin_sel(sel[0]));
	// 20-pin variant on the same bus; its handshakes match the first
	aps_pin_select #(.PIN20(1)) dut20 (.clk(clk), .rst(rst),
		.s_axi_awvalid(awv), .s_axi_awready(), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_bvalid(), .s_axi_bready(bry),
		.s_axi_bresp(), .s_axi_arvalid(arv), .s_axi_arready(),
		.s_axi_araddr(ara), .s_axi_rvalid(), .s_axi_rready(rry),
		.s_axi_rdata(rd2), .s_axi_rresp(), .ext_osc_running_flag(osc),
		.rx_data_pin_sel(sel2[4]), .serial_out_pin_sel(sel2[3]),
		.slave_select_pin_sel(sel2[2]), .timer_gate_pin_sel(sel2[1]),
		.tx_clock_pin_sel(sel2[0]));
	initial forever #5 clk = ~clk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task wrap_up;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// random stalls; a raised ready waits for its valid before it moves
	always @(posedge clk) begin
		if (!rry || rv)
			rry <= $urandom;
		if (!bry || bv)
			bry <= $urandom;
	end
	// oldest note against each answer beat
	always @(posedge clk) begin
		if (rv && rry) begin
			chk(rd, q.pop_front());
			chk(rd2, q2.pop_front());
			chk({30'h0, rr}, {30'h0, qr.pop_front()});
		end
		if (bv && bry)
			chk({30'h0, br}, {30'h0, qb.pop_front()});
	end
	task wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] e);
		bit ta, tw;
		qb.push_back(e);
		ta = 0;
		tw = 0;
		awa <= a;
		wd <= v;
		awv <= 1;
		wv <= 1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (awr && !ta) begin ta = 1; awv <= 0; end
			if (wrd && !tw) begin tw = 1; wv <= 0; end
		end
		do @(posedge clk); while (!(bv && bry));
	endtask
	task rdx(input logic [3:0] a, input logic [31:0] e);
		q.push_back(e);
		q2.push_back(a == 4'h0 ? e & 32'h8c : e);
		qr.push_back((a == 4'h0 || a == 4'h4) ? 2'h0 : 2'h2);
		ara <= a;
		arv <= 1;
		do @(posedge clk); while (!arr);
		arv <= 0;
		do @(posedge clk); while (!(rv && rry));
	endtask
	// main sequence; second reset proves the clear value again
	initial begin
		void'($urandom(79));
		repeat (10) @(posedge clk);
		rst <= 0;
		rdx(4'h0, 32'h0);
		wr(4'h0, 32'hffffffff, 2'h0);
		rdx(4'h0, 32'hec);
		chk({27'h0, sel}, 32'h1f);
		chk({27'h0, sel2}, 32'h13);
		d = $urandom;
		wr(4'h0, d, 2'h0);
		rdx(4'h0, d & 32'hec);
		chk({27'h0, sel}, {27'h0, d[7:5], d[3:2]});
		chk({27'h0, sel2}, {27'h0, d[7], 2'b00, d[3:2]});
		ws <= 4'h0;
		wr(4'h0, 32'h0, 2'h0);
		wr(4'h4, 32'h0, 2'h0);
		wr(4'h8, 32'h0, 2'h2);
		rdx(4'h0, d & 32'hec);
		$display("write tests done");
		osc <= 1;
		rdx(4'h4, 32'h1);
		osc <= 0;
		rdx(4'h4, 32'h0);
		rdx(4'h8, 32'h0);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		rdx(4'h0, 32'h0);
		$display("read tests done");
		wrap_up;
	end
	initial begin
		#100000;
		n_mismatch++;
		wrap_up;
	end
endmodule // aps_pin_select_tb
bind aps_pin_select aps_pin_select_checker u_chk (.clk(clk), .rst(rst),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .rx_data_pin_sel(rx_data_pin_sel));
`default_nettype wire
